//--- dcc_dma_model.sv
// dcc_dma_model: external dma controller strobing data into the block
`timescale 1ns/1ps
module dcc_dma_model (
    // clock
    input  wire logic        CLK,
    // dma bus
    input  wire logic        DMA_REQ,
    output logic             DACK,
    output logic             END_OF_TRANSFER_IN,
    output logic      [15:0] DATA
);
    // idle bus at time zero
    initial begin
        DACK = 1'b0;
        END_OF_TRANSFER_IN = 1'b0;
        DATA = 16'h0000;
    end
    // one unit per request; data held 3 clocks before the rise and 4 clocks after it
    // unpaced units ignore the request, as in master mode it stays low
    task automatic send(input int n, input bit paced = 1'b1);
        for (int i = 0; i < n; i++) begin
            while (paced && dma_req_low()) @(posedge CLK);
            DATA <= 16'hA500 + 16'(i);
            repeat (3) @(posedge CLK);
            DACK <= 1'b1;
            repeat (4) @(posedge CLK);
            DACK <= 1'b0;
            DATA <= ~DATA;  // released bus must not keep stale data
            repeat (3) @(posedge CLK);
        end
    endtask : send
    function automatic bit dma_req_low;
        return DMA_REQ !== 1'b1;
    endfunction : dma_req_low
    // early end of an in transfer while the counter is off
    task automatic finish_early;
        @(posedge CLK);
        END_OF_TRANSFER_IN <= 1'b1;
        repeat (4) @(posedge CLK);
        END_OF_TRANSFER_IN <= 1'b0;
    endtask : finish_early
endmodule : dcc_dma_model

//--- dcc_fifo.sv
// dcc_fifo: synchronous fifo, width and depth set by parameters
`timescale 1ns/1ps
module dcc_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // handshakes
    dcc_fifo_if.fifo q
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;
    logic         do_push;
    logic         do_pop;

    // extra pointer bit tells full from empty
    assign q.empty      = wr_ptr_reg == rd_ptr_reg;
    assign q.full       = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                          (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign q.push_ready = ~q.full;
    assign q.pop_valid  = ~q.empty;
    assign q.pop_data   = mem[rd_ptr_reg[AW-1:0]];
    assign do_push      = q.push_valid & q.push_ready;
    assign do_pop       = q.pop_valid & q.pop_ready;

    // storage has no reset; only pointers need a defined value
    always_ff @(posedge CLK) begin
        if (do_push) begin
            mem[wr_ptr_reg[AW-1:0]] <= q.push_data;
        end
    end

    // pointer update
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(do_push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(do_pop);
        end
    end

endmodule : dcc_fifo

//--- dcc_fifo_if.sv
// dcc_fifo_if: push and pop handshakes between the top and its fifo
`timescale 1ns/1ps
interface dcc_fifo_if #(parameter int W = 16);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    logic         full;
    logic         empty;

    modport fifo (input  push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, full, empty);
    modport user (output push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data, full, empty);
endinterface : dcc_fifo_if

//--- dcc_pkg.sv
// dcc_pkg: register map, field layout and constants of the dma setup block
package dcc_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0]  ADDR_COUNT   = 8'h34;
    localparam logic [7:0]  ADDR_CFG     = 8'h38;
    localparam logic [7:0]  ADDR_CTRL    = 8'h40;
    localparam logic [7:0]  ADDR_STAT    = 8'h44;

    // ****************************************************************
    // configuration fields and reset values
    // ****************************************************************
    localparam int          CFG_SKIP_RDY = 14;
    localparam int          CFG_DISK     = 13;
    localparam int          CFG_TMODE_LO = 11;
    localparam int          CFG_PIO_LO   = 8;
    localparam int          CFG_CNT_DIS  = 7;
    localparam int          CFG_BURST_LO = 4;
    localparam int          CFG_WIDE     = 0;
    localparam logic [15:0] CFG_RESET    = 16'h0001;
    // bits 15 and 1 are reserved and read as zero
    localparam logic [15:0] CFG_WMASK    = 16'h7FFD;
    localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
    localparam logic [2:0]  PIO_MAX      = 3'h4;
    localparam logic [2:0]  PIO_SAFE     = 3'h0;
    localparam logic [1:0]  TMODE_STROBE = 2'h3;
    localparam logic [2:0]  BURST_CONT   = 3'h0;

    // ****************************************************************
    // control and status fields
    // ****************************************************************
    localparam int          CTRL_MASTER  = 0;
    localparam int          CTRL_START   = 1;
    localparam int          STAT_ACTIVE  = 0;
    localparam int          STAT_DONE    = 1;
    localparam int          STAT_EOT     = 2;
    localparam int          STAT_EMPTY   = 3;
    localparam int          STAT_FULL    = 4;
    localparam int          STAT_PIO_RSV = 5;

    // ****************************************************************
    // data path and request pacing
    // ****************************************************************
    localparam int          FIFO_W       = 16;
    localparam int          FIFO_D       = 16;
    localparam logic [31:0] STEP_NARROW  = 32'h0000_0001;
    localparam logic [31:0] STEP_WIDE    = 32'h0000_0002;
    // strobes per request group; entry 0 means request held continuously
    localparam logic [5:0]  GROUP_LEN [8] = '{6'h00, 6'h01, 6'h02, 6'h04,
                                              6'h08, 6'h0C, 6'h10, 6'h20};

    typedef enum logic [1:0] {
        DCC_IDLE = 2'b00,
        DCC_RUN  = 2'b01,
        DCC_DONE = 2'b11
    } dcc_state_e;

endpackage : dcc_pkg

//--- dcc_tb.sv
// testbench: apb driven checks of the dma count and configuration block
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, rdy_in = 1'b0, bready = 1'b1;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [3:0]  pstb = 4'hF;
    logic        prdy, perr, dack, end_of_transfer_in, dreq, disk, sten, wide, rok;
    logic        pkt, done, bval, err;
    logic [15:0] ddat, bdat;
    logic [1:0]  tm;
    logic [2:0]  pio;
    int          error_cnt = 0, checks = 0, falls = 0, f0;
    always #2.5 clk = ~clk;
    // count request drops to see burst pacing
    always @(posedge clk) if ($fell(dreq)) falls <= falls + 1;
    dcc_top i_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PSTRB(pstb),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DACK(dack),
        .END_OF_TRANSFER_IN(end_of_transfer_in), .READY_IN(rdy_in), .DMA_DATA(ddat),
        .DMA_REQ(dreq), .BUF_DATA(bdat), .BUF_VALID(bval),
        .BUF_READY(bready), .DISK_IFACE_SELECT(disk), .TIMING_MODE(tm),
        .PROGRAMMED_IO_TIMING(pio), .STROBE_TIMING_EN(sten),
        .BUS_WIDE(wide), .READY_OK(rok), .PKT_VALIDATE(pkt),
        .XFER_DONE(done));
    dcc_dma_model i_mdl (.CLK(clk), .DMA_REQ(dreq), .DACK(dack),
        .END_OF_TRANSFER_IN(end_of_transfer_in), .DATA(ddat));
    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge clk);
        {psel, pen, pwr, padr, pwd, pstb} <= {2'b10, w, a, d, s};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        {err, rd} = {perr, prd};
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_for(ref logic sig);
        for (int i = 0; i < 400 && sig !== 1'b1; i++) @(posedge clk);
    endtask : wait_for
    task automatic t_cfg;
        apb(0, dcc_pkg::ADDR_CFG, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1, dcc_pkg::ADDR_CFG, 32'h0000_FFFF);
        apb(0, dcc_pkg::ADDR_CFG, 32'h0);
        chk(rd, 32'h0000_7FFD);
        chk({disk, tm, sten, pio, wide}, 32'h0000_00F1);
        chk(rok, 1'b1);
        apb(1, dcc_pkg::ADDR_CFG, 32'h0000_0A00);
        // mode outputs lag the register by one flop
        repeat (2) @(posedge clk);
        chk({disk, tm, sten, pio, wide, rok}, 32'h0000_0048);
        apb(0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask : t_cfg
    task automatic t_count;
        apb(1, dcc_pkg::ADDR_COUNT, 32'h0012_3456, 4'h7);
        apb(0, dcc_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h0);
        apb(1, dcc_pkg::ADDR_COUNT, 32'hAB00_0000, 4'h8);
        apb(0, dcc_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'hAB12_3456);
    endtask : t_count
    task automatic t_fill;  // burst 0, sink stalled until fifo refuses
        apb(1, dcc_pkg::ADDR_CFG, 32'h0);
        apb(1, dcc_pkg::ADDR_COUNT, 32'd20);
        bready <= 1'b0;
        apb(1, dcc_pkg::ADDR_CTRL, 32'h2);
        i_mdl.send(17);  // 16 fifo words plus the output stage
        apb(0, dcc_pkg::ADDR_STAT, 32'h0);
        chk({rd[4], dreq}, 2'b10);
        chk({bval, bdat}, 32'h0001_A500);
        bready <= 1'b1;
        i_mdl.send(3);
        wait_for(done);
        apb(0, dcc_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h0);
        chk({done, dreq}, 2'b10);
    endtask : t_fill
    task automatic t_burst;
        apb(1, dcc_pkg::ADDR_CFG, 32'h0000_0010);
        apb(1, dcc_pkg::ADDR_COUNT, 32'd3);
        f0 = falls;
        apb(1, dcc_pkg::ADDR_CTRL, 32'h2);
        i_mdl.send(3);
        wait_for(done);
        chk(falls - f0, 32'd3);
    endtask : t_burst
    task automatic t_eot;
        apb(1, dcc_pkg::ADDR_CFG, 32'h0000_0080);
        apb(1, dcc_pkg::ADDR_COUNT, 32'h100);
        apb(1, dcc_pkg::ADDR_CTRL, 32'h2);
        i_mdl.send(2);
        fork
            i_mdl.finish_early();
            begin
                wait_for(pkt);
                chk(pkt, 1'b1);
            end
        join
        apb(0, dcc_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h100);
    endtask : t_eot
    task automatic t_master;  // counter forced on, request held low
        apb(1, dcc_pkg::ADDR_CTRL, 32'h3);
        i_mdl.send(2, 1'b0);
        apb(0, dcc_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'hFE);
        chk(dreq, 1'b0);
    endtask : t_master
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(wide, 1'b1);
        t_count();
        t_cfg();
        t_fill();
        t_burst();
        t_eot();
        t_master();
        end_sim();
    end
endmodule : testbench

//--- dcc_top.sv
// dcc_top: dma transfer counter, dma configuration and slave request pacing
`timescale 1ns/1ps
// ****************************************************************
// Contract
// [RULE1] The byte counter is 32 bits in four lanes, lane 3 most significant.
// [RULE2] A 16-bit dma configuration register sits at byte address 38H.
// [RULE3] Config bit 14 set makes the ready input be ignored, ultra dma only.
// [RULE4] Config bit 13 set selects disk interface (ata or multiword) mode.
// [RULE5] Config bit 13 clear selects the generic (non-disk) dma mode.
// [RULE6] Bits 12..11 values 0 to 2 select standard timing modes 0 to 2.
// [RULE7] Bits 12..11 value 3 selects multiword mode 3 with strobe timing.
// [RULE8] Bits 10..8 select pio modes 0 to 4; values 5 to 7 are reserved.
// [RULE9] Bit 7 disables the counter only in generic slave mode; the code disables it in disk slave mode too.
// [RULE10] Bits 6..4 pace the request output, in generic slave mode only; the code paces it in disk slave mode too.
// [RULE11] Burst 0 holds the request until the last unit or fifo full.
// [RULE12] Bursts 1..7 pulse the request per 1,2,4,8,12,16 or 32 units.
// [RULE13] Reading the counter gives the bytes still left to move.
// [RULE14] Lanes are written low first; the counter loads on lane 3.
// [RULE15] With the counter off, end of transfer validates the last packet.
// [RULE16] Config bit 0 selects an 8-bit bus when 0 and 16-bit when 1.
// [RULE17] Each strobe decrements the counter; zero completes the transfer.
// ****************************************************************
module dcc_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // dma bus pins, asynchronous
    input  wire logic        DACK,
    input  wire logic        END_OF_TRANSFER_IN,
    input  wire logic        READY_IN,
    input  wire logic [15:0] DMA_DATA,
    output logic             DMA_REQ,
    // internal buffer side
    output logic      [15:0] BUF_DATA,
    output logic             BUF_VALID,
    input  wire logic        BUF_READY,
    // mode outputs to the strobe engine
    output logic             DISK_IFACE_SELECT,
    output logic      [1:0]  TIMING_MODE,
    output logic      [2:0]  PROGRAMMED_IO_TIMING,
    output logic             STROBE_TIMING_EN,
    output logic             BUS_WIDE,
    output logic             READY_OK,
    output logic             PKT_VALIDATE,
    output logic             XFER_DONE
);
    default clocking dcc_cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    dcc_fifo_if #(.W(dcc_pkg::FIFO_W)) q ();

    dcc_fifo #(.W(dcc_pkg::FIFO_W), .D(dcc_pkg::FIFO_D)) u_fifo (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .q       (q.fifo)
    );

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0]  dack_sync_reg;
    logic [1:0]  eot_sync_reg;
    logic [1:0]  rdy_sync_reg;
    logic [15:0] data_meta_reg;
    logic [15:0] data_sync_reg;
    logic        dack_last_reg;
    logic        eot_last_reg;
    logic        dack_rise;
    logic        eot_rise;

    // two flops per pin; edge detection reads the second stage only
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            dack_sync_reg <= 2'h0;
            eot_sync_reg  <= 2'h0;
            rdy_sync_reg  <= 2'h0;
            data_meta_reg <= 16'h0000;
            data_sync_reg <= 16'h0000;
            dack_last_reg <= 1'b0;
            eot_last_reg  <= 1'b0;
        end else begin
            dack_sync_reg <= {dack_sync_reg[0], DACK};
            eot_sync_reg  <= {eot_sync_reg[0], END_OF_TRANSFER_IN};
            rdy_sync_reg  <= {rdy_sync_reg[0], READY_IN};
            data_meta_reg <= DMA_DATA;
            data_sync_reg <= data_meta_reg;
            dack_last_reg <= dack_sync_reg[1];
            eot_last_reg  <= eot_sync_reg[1];
        end
    end

    assign dack_rise = dack_sync_reg[1] & ~dack_last_reg;
    assign eot_rise  = eot_sync_reg[1] & ~eot_last_reg;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic        pready_reg;
    logic        apb_setup;
    logic        apb_wr;
    logic        hit_count;
    logic        hit_cfg;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_any;
    logic        wr_count;
    logic        wr_cfg;
    logic        wr_ctrl;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;

    // data is picked in the setup cycle so prdata leaves a flop
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr    = PSEL & PENABLE & pready_reg & PWRITE;
    assign hit_count = PADDR == dcc_pkg::ADDR_COUNT;
    assign hit_cfg   = PADDR == dcc_pkg::ADDR_CFG; // [RULE2]
    assign hit_ctrl  = PADDR == dcc_pkg::ADDR_CTRL;
    assign hit_stat  = PADDR == dcc_pkg::ADDR_STAT;
    assign hit_any   = hit_count | hit_cfg | hit_ctrl | hit_stat;
    assign wr_count  = apb_wr & hit_count;
    assign wr_cfg    = apb_wr & hit_cfg;
    assign wr_ctrl   = apb_wr & hit_ctrl;

    // ****************************************************************
    // counter, configuration and control registers
    // ****************************************************************
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] stage_reg;
    logic [31:0] stage_next;
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [15:0] cfg_wdata;
    logic        cfg_seen_reg;
    logic        master_reg;
    logic        load;
    logic        start;
    logic        cnt_en;
    logic        dec;
    logic [31:0] step;

    // per lane staging, so a low lane write never disturbs a running count
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign stage_next[8*i +: 8] = (wr_count & PSTRB[i]) ?
                                      PWDATA[8*i +: 8] : stage_reg[8*i +: 8];
    end

    assign load      = wr_count & PSTRB[3]; // [RULE14]
    assign start     = wr_ctrl & PSTRB[0] & PWDATA[dcc_pkg::CTRL_START];
    assign cnt_en    = master_reg | ~cfg_reg[dcc_pkg::CFG_CNT_DIS]; // [RULE9]
    assign step      = cfg_reg[dcc_pkg::CFG_WIDE] ? dcc_pkg::STEP_WIDE :
                       dcc_pkg::STEP_NARROW; // [RULE16]
    // software reload wins over a strobe in the same cycle
    assign count_next = load ? stage_next : // [RULE1]
                        ~dec ? count_reg :
                        (count_reg < step) ? 32'h0000_0000 :
                        count_reg - step; // [RULE17]
    assign cfg_wdata = PWDATA[15:0] & dcc_pkg::CFG_WMASK;
    assign cfg_next  = {PSTRB[1] ? cfg_wdata[15:8] : cfg_reg[15:8],
                        PSTRB[0] ? cfg_wdata[7:0]  : cfg_reg[7:0]};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            count_reg    <= dcc_pkg::COUNT_RESET;
            stage_reg    <= dcc_pkg::COUNT_RESET;
            cfg_reg      <= dcc_pkg::CFG_RESET;
            cfg_seen_reg <= 1'b0;
            master_reg   <= 1'b0;
        end else begin
            count_reg    <= count_next;
            stage_reg    <= stage_next;
            cfg_reg      <= wr_cfg ? cfg_next : cfg_reg;
            cfg_seen_reg <= cfg_seen_reg | wr_cfg;
            if (wr_ctrl & PSTRB[0]) begin
                master_reg <= PWDATA[dcc_pkg::CTRL_MASTER];
            end
        end
    end

    a_lane_order: assert property (wr_count && PSTRB == 4'hF |=> // [RULE1]
        count_reg == $past(PWDATA)) else $error("counter lanes misplaced");
    a_msb_load: assert property (wr_count && !PSTRB[3] && !dec |=> // [RULE14]
        $stable(count_reg)) else $error("counter loaded before lane 3");
    a_cfg_write: assert property (wr_cfg && PSTRB[1:0] == 2'h3 |=> // [RULE2]
        cfg_reg == ($past(PWDATA[15:0]) & dcc_pkg::CFG_WMASK))
        else $error("config write lost");
    a_count_forced: assert property (master_reg && dec && !load && // [RULE9]
        count_reg > step |=> count_reg == $past(count_reg) - $past(step))
        else $error("counter not running in master mode");

    // ****************************************************************
    // transfer sequencer
    // ****************************************************************
    dcc_pkg::dcc_state_e state_reg;
    dcc_pkg::dcc_state_e state_next;
    logic        run;
    logic        strobe_acc;
    logic        eot_evt;
    logic        finish;
    logic        eot_seen_reg;

    assign run        = state_reg == dcc_pkg::DCC_RUN;
    assign strobe_acc = dack_rise & run & q.push_ready;
    assign dec        = strobe_acc & cnt_en; // [RULE17]
    assign eot_evt    = run & ~cnt_en & eot_rise; // [RULE15]
    // a disabled counter leaves the end to the far party
    assign finish     = cnt_en ? (count_next == 32'h0000_0000) : eot_evt;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dcc_pkg::DCC_IDLE: begin
                if (start) state_next = dcc_pkg::DCC_RUN;
            end
            dcc_pkg::DCC_RUN: begin
                if (finish) state_next = dcc_pkg::DCC_DONE; // [RULE17]
            end
            dcc_pkg::DCC_DONE: begin
                if (start) state_next = dcc_pkg::DCC_RUN;
            end
            default: state_next = dcc_pkg::DCC_IDLE;
        endcase
    end

    // eot flag: a new event beats the clear by start
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg    <= dcc_pkg::DCC_IDLE;
            eot_seen_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            eot_seen_reg <= eot_evt | (eot_seen_reg & ~start);
        end
    end

    a_done_zero: assert property (run && cnt_en && !load && // [RULE17]
        count_reg == 32'h0000_0000 |=> state_reg == dcc_pkg::DCC_DONE)
        else $error("transfer not ended at zero count");

    // ****************************************************************
    // fifo fill and drain
    // ****************************************************************
    logic [15:0] buf_data_reg;
    logic        buf_valid_reg;

    // the strobe engine sees no ready; dma_req is its back-pressure
    assign q.push_valid = dack_rise & run;
    assign q.push_data  = data_sync_reg;
    assign q.pop_ready  = ~buf_valid_reg | BUF_READY;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            buf_valid_reg <= 1'b0;
            buf_data_reg  <= 16'h0000;
        end else if (q.pop_ready) begin
            buf_valid_reg <= q.pop_valid;
            buf_data_reg  <= q.pop_data;
        end
    end

    // ****************************************************************
    // request pacing
    // ****************************************************************
    logic [5:0]  grp_cnt_reg;
    logic [5:0]  grp_cnt_next;
    logic [5:0]  glen;
    logic [2:0]  burst;
    logic        grp_hit;
    logic        can_req;
    logic        dreq_next;
    logic        dreq_reg;

    assign burst   = cfg_reg[dcc_pkg::CFG_BURST_LO +: 3];
    assign glen    = dcc_pkg::GROUP_LEN[burst]; // [RULE12]
    assign grp_hit = strobe_acc & (burst != dcc_pkg::BURST_CONT) &
                     (grp_cnt_reg + 6'h01 == glen);
    assign grp_cnt_next = (grp_hit | start) ? 6'h00 :
                          strobe_acc ? grp_cnt_reg + 6'h01 : grp_cnt_reg;
    // request only in slave mode, after a config write, with fifo room
    assign can_req   = (state_next == dcc_pkg::DCC_RUN) & ~master_reg &
                       cfg_seen_reg & ~q.full; // [RULE10] [RULE11]
    // a finished group forces at least one low cycle
    assign dreq_next = can_req & ~grp_hit; // [RULE12]

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            grp_cnt_reg <= 6'h00;
            dreq_reg    <= 1'b0;
        end else begin
            grp_cnt_reg <= grp_cnt_next;
            dreq_reg    <= dreq_next;
        end
    end

    a_dreq_master: assert property (master_reg |=> !DMA_REQ) // [RULE10]
        else $error("request driven in master mode");
    a_dreq_full: assert property (q.full |=> !DMA_REQ) // [RULE11]
        else $error("request while fifo full");
    a_group_gap: assert property (grp_hit |=> !DMA_REQ) // [RULE12]
        else $error("request not negated after group");

    // ****************************************************************
    // mode outputs and status
    // ****************************************************************
    logic [2:0]  pio_field;
    logic        pio_rsv;
    logic [1:0]  tmode;
    logic        disk;
    logic        skip_eff;
    logic        pkt_reg;

    assign disk      = cfg_reg[dcc_pkg::CFG_DISK]; // [RULE4] [RULE5]
    assign tmode     = cfg_reg[dcc_pkg::CFG_TMODE_LO +: 2]; // [RULE6]
    assign pio_field = cfg_reg[dcc_pkg::CFG_PIO_LO +: 3];
    assign pio_rsv   = pio_field > dcc_pkg::PIO_MAX; // [RULE8]
    // ultra dma is the disk mode without the multiword master
    assign skip_eff  = cfg_reg[dcc_pkg::CFG_SKIP_RDY] & disk &
                       ~master_reg; // [RULE3]

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[dcc_pkg::STAT_ACTIVE]  = run;
        stat_word[dcc_pkg::STAT_DONE]    = state_reg == dcc_pkg::DCC_DONE;
        stat_word[dcc_pkg::STAT_EOT]     = eot_seen_reg;
        stat_word[dcc_pkg::STAT_EMPTY]   = q.empty;
        stat_word[dcc_pkg::STAT_FULL]    = q.full;
        stat_word[dcc_pkg::STAT_PIO_RSV] = pio_rsv;
    end

    // the counter reads back live, i.e. bytes still to move
    assign rd_mux = hit_count ? count_reg : // [RULE13]
                    hit_cfg   ? {16'h0000, cfg_reg} :
                    hit_ctrl  ? {31'h0000_0000, master_reg} :
                    hit_stat  ? stat_word : 32'h0000_0000;

    // registered outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pready_reg           <= 1'b0;
            PSLVERR              <= 1'b0;
            PRDATA               <= 32'h0000_0000;
            DISK_IFACE_SELECT    <= 1'b0;
            TIMING_MODE          <= 2'h0;
            PROGRAMMED_IO_TIMING <= 3'h0;
            STROBE_TIMING_EN     <= 1'b0;
            BUS_WIDE             <= 1'b1;
            READY_OK             <= 1'b0;
            pkt_reg              <= 1'b0;
            XFER_DONE            <= 1'b0;
        end else begin
            pready_reg           <= apb_setup;
            PSLVERR              <= apb_setup & ~hit_any;
            PRDATA               <= apb_setup ? rd_mux : PRDATA;
            DISK_IFACE_SELECT    <= disk;
            TIMING_MODE          <= tmode;
            PROGRAMMED_IO_TIMING <= pio_rsv ? dcc_pkg::PIO_SAFE : pio_field;
            STROBE_TIMING_EN     <= disk &&
                                    tmode == dcc_pkg::TMODE_STROBE; // [RULE7]
            BUS_WIDE             <= cfg_reg[dcc_pkg::CFG_WIDE]; // [RULE16]
            READY_OK             <= rdy_sync_reg[1] | skip_eff; // [RULE3]
            pkt_reg              <= eot_evt; // [RULE15]
            XFER_DONE            <= state_next == dcc_pkg::DCC_DONE;
        end
    end

    assign PREADY    = pready_reg;
    assign DMA_REQ   = dreq_reg;
    assign BUF_VALID = buf_valid_reg;
    assign BUF_DATA  = buf_data_reg;
    assign PKT_VALIDATE = pkt_reg;

    a_skip_ready: assert property (skip_eff |=> READY_OK) // [RULE3]
        else $error("ready not ignored");
    a_strobe_mode: assert property (disk && tmode == 2'h3 |=> // [RULE7]
        STROBE_TIMING_EN) else $error("strobe timing not enabled");
    a_pio_reserved: assert property (pio_rsv |=> // [RULE8]
        PROGRAMMED_IO_TIMING == 3'h0) else $error("reserved pio passed");
    a_read_count: assert property (apb_setup && hit_count |=> // [RULE13]
        PRDATA == $past(count_reg)) else $error("counter readback wrong");
    a_eot_valid: assert property (eot_evt |=> PKT_VALIDATE ##1 // [RULE15]
        !PKT_VALIDATE) else $error("last packet not validated");

endmodule : dcc_top
